// File: wwdt_top.sv
// Windowed watchdog timer with AXI4-Lite register access.
// Assumes fil_clk is the slow oscillator, asynchronous to aclk, and that
// option_byte is stable while aresetn is low and the cycle after release.
`timescale 1ns/10ps
`default_nettype none

module wwdt_top #(
    parameter int CNT_W = 17
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output var  logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output var  logic             s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]       s_axi_bresp,
    output var  logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output var  logic             s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0]      s_axi_rdata,
    output var  logic [1:0]       s_axi_rresp,
    output var  logic             s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Slow oscillator and configuration
    input  wire logic             fil_clk,
    input  wire logic [7:0]       option_byte,
    // Standby modes
    input  wire logic             halt_mode,
    input  wire logic             stop_mode,
    input  wire logic             snooze_mode,
    // Outputs to the system
    output var  logic             interval_irq,
    output var  logic             wdt_reset_req,
    output var  logic             watchdog_cause_flag
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] ovf_limit(input logic [2:0] sel);
        case (sel)
            3'h0:    ovf_limit = CNT_W'(1) << 6;
            3'h1:    ovf_limit = CNT_W'(1) << 7;
            3'h2:    ovf_limit = CNT_W'(1) << 8;
            3'h3:    ovf_limit = CNT_W'(1) << 9;
            3'h4:    ovf_limit = CNT_W'(1) << 11;
            3'h5:    ovf_limit = CNT_W'(1) << 13;
            3'h6:    ovf_limit = CNT_W'(1) << 14;
            default: ovf_limit = CNT_W'(1) << 16;
        endcase
    endfunction

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        addr_hit = (a[7:2] == off[7:2]);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]              awaddr_q, awaddr_d;
    logic [31:0]             wdata_q, wdata_d, rdata_d;
    logic [3:0]              wstrb_q, wstrb_d;
    logic                    aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic                    awready_d, wready_d, arready_d;
    logic                    bvalid_d, rvalid_d;
    logic [1:0]              bresp_d, rresp_d;
    logic                    do_wr;
    logic                    wr_key, wr_bitop, wr_cause;

    logic                    s1_q, s2_q, s3_q, lvl_q, lvl_d, tick;
    wwdt_pkg::wwdt_state_e   state_q, state_d;
    logic [7:0]              opt_q, opt_d;
    logic                    opt_valid_q, opt_valid_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic [CNT_W-1:0]        lim, open_start, irq_point;
    logic                    clr_pend_q, clr_pend_d;
    logic                    first_q, first_d;
    logic                    stby_prev_q, stby_prev_d;
    logic                    irq_d, rst_d, cause_d;
    logic                    hold, closed, fire, clr_now;

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign do_wr    = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_key   = do_wr & wstrb_q[0]
                      & addr_hit(awaddr_q, wwdt_pkg::KEY_OFF);
    assign wr_bitop = do_wr & addr_hit(awaddr_q, wwdt_pkg::BITOP_OFF);
    assign wr_cause = do_wr & wstrb_q[0]
                      & addr_hit(awaddr_q, wwdt_pkg::CAUSE_OFF);

    always_comb begin
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        bvalid_d  = s_axi_bvalid;
        bresp_d   = s_axi_bresp;
        rvalid_d  = s_axi_rvalid;
        rresp_d   = s_axi_rresp;
        rdata_d   = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_d  = s_axi_awaddr;
            aw_full_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
            w_full_d = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            if (addr_hit(awaddr_q, wwdt_pkg::KEY_OFF)
                || addr_hit(awaddr_q, wwdt_pkg::BITOP_OFF)
                || addr_hit(awaddr_q, wwdt_pkg::CAUSE_OFF)) begin
                bresp_d = wwdt_pkg::RESP_OKAY;
            end else begin
                bresp_d = wwdt_pkg::RESP_SLVERR;
            end
        end
        awready_d = ~aw_full_d & ~bvalid_d;
        wready_d  = ~w_full_d & ~bvalid_d;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = wwdt_pkg::RESP_OKAY;
            rdata_d  = 32'h00000000;
            if (addr_hit(s_axi_araddr, wwdt_pkg::KEY_OFF)
                || addr_hit(s_axi_araddr, wwdt_pkg::BITOP_OFF)) begin
                rdata_d[7:0] = opt_q[wwdt_pkg::OPT_EN_POS]
                               ? wwdt_pkg::KEY_READ_ON
                               : wwdt_pkg::KEY_READ_OFF;
            end else if (addr_hit(s_axi_araddr, wwdt_pkg::STATUS_OFF)) begin
                rdata_d[wwdt_pkg::ST_OPT_LSB +: 8] = opt_q;
                rdata_d[wwdt_pkg::ST_OPEN_POS]     = ~closed | ~first_q;
                rdata_d[wwdt_pkg::ST_FIRST_POS]    = first_q;
                rdata_d[wwdt_pkg::ST_RST_POS]      = wdt_reset_req;
            end else if (addr_hit(s_axi_araddr, wwdt_pkg::COUNT_OFF)) begin
                rdata_d[CNT_W-1:0] = cnt_q;
            end else if (addr_hit(s_axi_araddr, wwdt_pkg::CAUSE_OFF)) begin
                rdata_d[wwdt_pkg::CAUSE_FLAG_POS] = watchdog_cause_flag;
            end else begin
                rresp_d = wwdt_pkg::RESP_SLVERR;
            end
        end
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            awaddr_q      <= awaddr_d;
            wdata_q       <= wdata_d;
            wstrb_q       <= wstrb_d;
            aw_full_q     <= aw_full_d;
            w_full_q      <= w_full_d;
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_bresp   <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rresp   <= rresp_d;
            s_axi_rdata   <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Slow oscillator tick
    // ------------------------------------------------------------------
    always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
        tick  = lvl_d & ~lvl_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q  <= fil_clk;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog core
    // ------------------------------------------------------------------
    always_comb begin
        lim       = ovf_limit(opt_q[wwdt_pkg::OPT_OVF_LSB +: 3]);
        irq_point = lim - (lim >> 2);
        if (!opt_q[wwdt_pkg::OPT_STBY_POS]) begin
            open_start = CNT_W'(0);
        end else if (opt_q[wwdt_pkg::OPT_WIN_LSB +: 2] == wwdt_pkg::WIN_50) begin
            open_start = lim >> 1;
        end else if (opt_q[wwdt_pkg::OPT_WIN_LSB +: 2] == wwdt_pkg::WIN_75) begin
            open_start = lim >> 2;
        end else begin
            open_start = CNT_W'(0);
        end
        closed = (cnt_q < open_start);
        hold   = (halt_mode | stop_mode | snooze_mode)
                 & ~opt_q[wwdt_pkg::OPT_STBY_POS];

        state_d     = state_q;
        opt_d       = opt_q;
        opt_valid_d = 1'b1;
        cnt_d       = cnt_q;
        clr_pend_d  = clr_pend_q;
        first_d     = first_q;
        stby_prev_d = halt_mode | stop_mode;
        irq_d       = 1'b0;
        rst_d       = wdt_reset_req;
        cause_d     = watchdog_cause_flag & ~(wr_cause
                      & wdata_q[wwdt_pkg::CAUSE_FLAG_POS]);
        fire        = 1'b0;
        clr_now     = 1'b0;

        case (state_q)
            wwdt_pkg::WWDT_IDLE: begin
                if (!opt_valid_q) begin
                    opt_d = option_byte;
                    if (option_byte[wwdt_pkg::OPT_EN_POS]) begin
                        state_d = wwdt_pkg::WWDT_RUN;
                    end
                end
            end
            wwdt_pkg::WWDT_RUN: begin
                if (wr_bitop) begin
                    fire = 1'b1;
                end else if (wr_key) begin
                    if (wdata_q[7:0] != wwdt_pkg::KEY_VALUE) begin
                        fire = 1'b1;
                    end else if (first_q && closed) begin
                        fire = 1'b1;
                    end else begin
                        clr_now = 1'b1;
                        first_d = 1'b1;
                    end
                end
                if (stby_prev_q && !(halt_mode | stop_mode)
                    && !opt_q[wwdt_pkg::OPT_STBY_POS]) begin
                    cnt_d      = CNT_W'(0);
                    clr_pend_d = 1'b0;
                end else if (tick && !hold) begin
                    if (clr_pend_q || clr_now) begin
                        cnt_d      = CNT_W'(0);
                        clr_pend_d = 1'b0;
                    end else if (cnt_q == lim - CNT_W'(1)) begin
                        fire = 1'b1;
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                        if (cnt_d == irq_point
                            && opt_q[wwdt_pkg::OPT_IRQ_POS]) begin
                            irq_d = 1'b1;
                        end
                    end
                end else if (clr_now) begin
                    clr_pend_d = 1'b1;
                end
                if (fire) begin
                    state_d = wwdt_pkg::WWDT_FIRED;
                    rst_d   = 1'b1;
                    cause_d = 1'b1;
                end
            end
            default: begin
                state_d = wwdt_pkg::WWDT_FIRED;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q             <= wwdt_pkg::WWDT_IDLE;
            opt_q               <= wwdt_pkg::OPT_RESET;
            opt_valid_q         <= 1'b0;
            cnt_q               <= wwdt_pkg::CNT_RESET;
            clr_pend_q          <= 1'b0;
            first_q             <= 1'b0;
            stby_prev_q         <= 1'b0;
            interval_irq        <= 1'b0;
            wdt_reset_req       <= 1'b0;
            watchdog_cause_flag <= 1'b0;
        end else begin
            state_q             <= state_d;
            opt_q               <= opt_d;
            opt_valid_q         <= opt_valid_d;
            cnt_q               <= cnt_d;
            clr_pend_q          <= clr_pend_d;
            first_q             <= first_d;
            stby_prev_q         <= stby_prev_d;
            interval_irq        <= irq_d;
            wdt_reset_req       <= rst_d;
            watchdog_cause_flag <= cause_d;
        end
    end

endmodule // wwdt_top

`default_nettype wire

// File: wwdt_pkg.sv
// Constants shared by the windowed watchdog timer.
// Assumes a 32-bit AXI4-Lite register bus.
package wwdt_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] KEY_OFF    = 8'h00;
    localparam logic [7:0] BITOP_OFF  = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam logic [7:0] COUNT_OFF  = 8'h0C;
    localparam logic [7:0] CAUSE_OFF  = 8'h10;

    // ------------------------------------------------------------------
    // Key and read-back values
    // ------------------------------------------------------------------
    localparam logic [7:0] KEY_VALUE    = 8'hAC;
    localparam logic [7:0] KEY_READ_ON  = 8'h9A;
    localparam logic [7:0] KEY_READ_OFF = 8'h1A;

    // ------------------------------------------------------------------
    // Option byte fields and cause flag bit
    // ------------------------------------------------------------------
    localparam int OPT_STBY_POS   = 0;
    localparam int OPT_OVF_LSB    = 1;
    localparam int OPT_EN_POS     = 4;
    localparam int OPT_WIN_LSB    = 5;
    localparam int OPT_IRQ_POS    = 7;
    localparam int CAUSE_FLAG_POS = 4;

    // Status register fields
    localparam int ST_OPT_LSB   = 0;
    localparam int ST_OPEN_POS  = 8;
    localparam int ST_FIRST_POS = 9;
    localparam int ST_RST_POS   = 10;

    // Window encodings
    localparam logic [1:0] WIN_50  = 2'h1;
    localparam logic [1:0] WIN_75  = 2'h2;

    // Reset values
    localparam logic [7:0]  OPT_RESET = 8'h00;
    localparam logic [16:0] CNT_RESET = 17'h00000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Watchdog state
    typedef enum logic [1:0] {
        WWDT_IDLE  = 2'b00,
        WWDT_RUN   = 2'b01,
        WWDT_FIRED = 2'b10
    } wwdt_state_e;

endpackage : wwdt_pkg

// File: wwdt_top_asserts.sv
// Checker for the watchdog top: option, error and pulse relations.
// Bound to wwdt_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module wwdt_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    // Watchdog
    input wire logic [7:0]  option_byte,
    input wire logic        interval_irq,
    input wire logic        wdt_reset_req,
    input wire logic        watchdog_cause_flag
);
    // ------------------------------------------------
    // Options latched at release, last accepted write
    // ------------------------------------------------
    logic [7:0] opt_q, opt_d, aw_q, aw_d, wd_q, wd_d;
    logic       up_q, up_d, ws_q, ws_d;
    always_comb begin
        up_d  = aresetn;
        opt_d = (aresetn && !up_q) ? option_byte : opt_q;
        aw_d  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_q;
        wd_d  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : wd_q;
        ws_d  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : ws_q;
    end
    always_ff @(posedge aclk) begin
        {up_q, opt_q, aw_q, wd_q, ws_q} <= {up_d, opt_d, aw_d, wd_d, ws_d};
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    irq_pulse_a: assert property (interval_irq |=> !interval_irq)
        else $error("interval pulse longer than one cycle");
    irq_opt_a: assert property (
        interval_irq |-> opt_q[wwdt_pkg::OPT_IRQ_POS])
        else $error("interval pulse while option off");
    idle_req_a: assert property (
        up_q && !opt_q[wwdt_pkg::OPT_EN_POS] |-> !wdt_reset_req)
        else $error("reset request while counting disabled");
    idle_irq_a: assert property (
        up_q && !opt_q[wwdt_pkg::OPT_EN_POS] |-> !interval_irq)
        else $error("interval pulse while counting disabled");
    cause_set_a: assert property (
        $rose(wdt_reset_req) |-> ##[0:1] watchdog_cause_flag)
        else $error("cause flag not set with reset request");
    req_hold_a: assert property (wdt_reset_req |=> wdt_reset_req)
        else $error("reset request dropped");
    alias_rst_a: assert property (
        $rose(s_axi_bvalid) && aw_q == wwdt_pkg::BITOP_OFF
        && opt_q[wwdt_pkg::OPT_EN_POS] |-> ##[1:2] wdt_reset_req)
        else $error("bit access gave no reset request");
    bad_key_a: assert property (
        $rose(s_axi_bvalid) && aw_q == wwdt_pkg::KEY_OFF && ws_q
        && wd_q != wwdt_pkg::KEY_VALUE && opt_q[wwdt_pkg::OPT_EN_POS]
        |-> ##[1:2] wdt_reset_req)
        else $error("wrong key gave no reset request");
    cover property (interval_irq);
    cover property ($rose(wdt_reset_req));
    cover property ($rose(s_axi_bvalid) && aw_q == wwdt_pkg::KEY_OFF);
endmodule // wwdt_asserts

bind wwdt_top wwdt_asserts i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .option_byte(option_byte),
    .interval_irq(interval_irq), .wdt_reset_req(wdt_reset_req),
    .watchdog_cause_flag(watchdog_cause_flag)
);
`default_nettype wire

// File: wwdt_tb_top.sv
// Self-checking bench for the windowed watchdog timer top.
// Assumes the package, the design and its bound checker.
`timescale 1ns/10ps
`default_nettype none

module wwdt_tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0, fil_clk = 1'b0;
    logic        halt_mode = 1'b0, stop_mode = 1'b0, snooze_mode = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic        arready, rvalid, irq, req, flag;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, option_byte = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    int          num_errors = 0, cmp_count = 0, irq_cnt = 0;
    int          ovf_n[5] = '{64, 128, 256, 512, 2048};
    wwdt_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fil_clk(fil_clk), .option_byte(option_byte),
        .halt_mode(halt_mode), .stop_mode(stop_mode),
        .snooze_mode(snooze_mode), .interval_irq(irq),
        .wdt_reset_req(req), .watchdog_cause_flag(flag)
    );
    initial forever #12.5 aclk = ~aclk;
    always @(posedge aclk) if (irq === 1'b1) irq_cnt++;
    initial begin
        #1500000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
    // --------------------------------------------
    // Bus, tick and check helpers
    // --------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rst(input logic [7:0] opt);
        aresetn     <= 1'b0;
        option_byte <= opt;
        halt_mode   <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        irq_cnt = 0;
    endtask
    // n slow oscillator periods, each long enough for the input filter
    task automatic tick(input int n);
        repeat (n) begin
            fil_clk <= 1'b1;
            repeat (4) @(posedge aclk);
            fil_clk <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int t;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        t = 0;
        do begin
            @(posedge aclk);
            t++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        chk(t < 50, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int t;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        t = 0;
        do begin
            @(posedge aclk);
            t++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        chk(rresp, wwdt_pkg::RESP_OKAY);
        rready <= 1'b0;
        chk(t < 50, 1'b1);
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // --------------------------------------------
    // Scenarios
    // --------------------------------------------
    task automatic t_ovf(input logic [2:0] c);
        rst({4'hF, c, 1'b1});
        halt_mode <= 1'b1;
        tick(ovf_n[c] - 1);
        chk(req, 1'b0);
        chk(irq_cnt, 1);
        tick(1);
        chk(req, 1'b1);
        chk(flag, 1'b1);
        $display("overflow code %0d done", c);
    endtask
    task automatic t_win;
        logic [31:0] d;
        logic [1:0]  r;
        rst(8'hB1);
        rd(wwdt_pkg::KEY_OFF, d);
        chk(d[7:0], wwdt_pkg::KEY_READ_ON);
        tick(5);
        wr(wwdt_pkg::KEY_OFF, wwdt_pkg::KEY_VALUE, r);
        chk(r, wwdt_pkg::RESP_OKAY);
        tick(5);
        chk(req, 1'b0);
        rd(wwdt_pkg::COUNT_OFF, d);
        chk(d >= 32'h3 && d <= 32'h4, 1'b1);
        wr(wwdt_pkg::KEY_OFF, wwdt_pkg::KEY_VALUE, r);
        repeat (2) @(posedge aclk);
        chk(req, 1'b1);
        // 75 percent window: closed below N/4, open from there
        rst(8'hD1);
        tick(2);
        wr(wwdt_pkg::KEY_OFF, wwdt_pkg::KEY_VALUE, r);
        tick(20);
        wr(wwdt_pkg::KEY_OFF, wwdt_pkg::KEY_VALUE, r);
        tick(2);
        chk(req, 1'b0);
        rd(wwdt_pkg::COUNT_OFF, d);
        chk(d <= 32'h1, 1'b1);
        tick(14);
        wr(wwdt_pkg::KEY_OFF, wwdt_pkg::KEY_VALUE, r);
        repeat (2) @(posedge aclk);
        chk(req, 1'b1);
        $display("window test done");
    endtask
    task automatic t_err;
        logic [1:0] r;
        for (int i = 0; i < 2; i++) begin
            rst(8'hF1);
            tick(3);
            wr(i ? wwdt_pkg::BITOP_OFF : wwdt_pkg::KEY_OFF, 32'h55, r);
            repeat (2) @(posedge aclk);
            chk(req, 1'b1);
            chk(flag, 1'b1);
            wr(wwdt_pkg::CAUSE_OFF, 32'h10, r);
            chk(flag, 1'b0);
        end
        $display("error write test done");
    endtask
    task automatic t_dis;
        logic [31:0] d;
        logic [1:0]  r;
        rst(8'hE1);
        rd(wwdt_pkg::KEY_OFF, d);
        chk(d[7:0], wwdt_pkg::KEY_READ_OFF);
        wr(8'h20, 32'h0, r);
        chk(r, wwdt_pkg::RESP_SLVERR);
        tick(70);
        chk(req, 1'b0);
        rd(wwdt_pkg::COUNT_OFF, d);
        chk(d, 32'h0);
        $display("disabled test done");
    endtask
    task automatic t_stby;
        logic [31:0] d;
        logic [1:0]  r;
        rst(8'hB0);
        tick(63);
        wr(wwdt_pkg::KEY_OFF, wwdt_pkg::KEY_VALUE, r);
        tick(3);
        wr(wwdt_pkg::KEY_OFF, wwdt_pkg::KEY_VALUE, r);
        tick(4);
        chk(req, 1'b0);
        stop_mode <= 1'b1;
        tick(70);
        chk(req, 1'b0);
        stop_mode <= 1'b0;
        repeat (2) @(posedge aclk);
        rd(wwdt_pkg::COUNT_OFF, d);
        chk(d, 32'h0);
        snooze_mode <= 1'b1;
        tick(70);
        chk(req, 1'b0);
        snooze_mode <= 1'b0;
        tick(3);
        rd(wwdt_pkg::COUNT_OFF, d);
        chk(d, 32'h3);
        $display("standby test done");
    endtask
    initial begin
        for (int c = 0; c < 5; c++) t_ovf(3'(c));
        t_win();
        t_err();
        t_dis();
        t_stby();
        stop_test();
    end
endmodule // wwdt_tb_top
`default_nettype wire
